// [rtl/rpd_reset_power_down.sv]
`timescale 1ns/1ps
// Function
// - Reset pin low halts oscillator and enters minimum-power power-down.
// - Entering power down initialises control logic at once.
// - Rate and bit-length settings survive reset; memories untouched.
// - Reset during record or playback stops operation immediately.
// - All internal operation halts while powered down.
// - Data bus lines float during power down, whatever strobes do.
// - All four memory selects driven high during power down.
module rpd_reset_power_down
	import rpd_pkg::*;
#(
	parameter int SETTLE_CYC = OSC_SETTLE_CYC
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic resetPin_n,
	input wire logic oscillator_input,
	input wire logic readStrobe_n,
	input wire logic chipEnable_n,
	input wire logic cmdValid,
	input wire logic [1:0] cmdOp,
	input wire logic settingWrite,
	input wire rpd_setting_t settingIn,
	input wire logic [DATA_W-1:0] readData,
	input wire logic [SEL_W-1:0] memorySelectReq_n,
	output logic powerDown,
	output logic oscEnable,
	output logic cmdReady,
	output rpd_op_t opState,
	output rpd_setting_t setting,
	output rpd_pins_t pins
);
	// ==================================================================
	// Pin synchronisers
	logic rstMeta, rstSync_n, rdMeta, rdSync_n, ceMeta, ceSync_n;
	logic oscMeta, oscSync;
	logic settled;

	// Two-stage sync of all pin inputs
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rstMeta <= 1'b0;
			rstSync_n <= 1'b0;
			rdMeta <= 1'b1;
			rdSync_n <= 1'b1;
			ceMeta <= 1'b1;
			ceSync_n <= 1'b1;
			oscMeta <= 1'b0;
			oscSync <= 1'b0;
		end
		else
		begin
			rstMeta <= resetPin_n;
			rstSync_n <= rstMeta;
			rdMeta <= readStrobe_n;
			rdSync_n <= rdMeta;
			ceMeta <= chipEnable_n;
			ceSync_n <= ceMeta;
			oscMeta <= oscillator_input;
			oscSync <= oscMeta;
		end
	end

	// ==================================================================
	// Power-down state and oscillator control
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			powerDown <= 1'b1;
			oscEnable <= 1'b0;
		end
		else
		begin
			powerDown <= !rstSync_n;
			oscEnable <= rstSync_n;
		end
	end

	// Settle timer holds off commands after oscillator restart
	rpd_settle_timer #(
		.SETTLE_CYC(SETTLE_CYC)
	) u_settle (
		.sys_clk(sys_clk),
		.rst(rst),
		.powerDown(powerDown),
		.settled(settled)
	);

	// Command acceptance only when powered up and settled
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cmdReady <= 1'b0;
		else
			cmdReady <= settled && !powerDown && rstSync_n;
	end

	// ==================================================================
	// Control state: cleared on power down, abandons any operation
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			opState <= RPD_IDLE;
		else if (powerDown || !rstSync_n)
			opState <= RPD_IDLE;
		else if (cmdValid && cmdReady)
		begin
			case (cmdOp)
				2'h1: opState <= RPD_RECORD;
				2'h2: opState <= RPD_PLAY;
				default: opState <= RPD_IDLE;
			endcase
		end
	end

	// ==================================================================
	// Settings: only rst (power-on) clears them, reset pin does not
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			setting.sampleRate <= RATE_RST;
			setting.bitLength <= BITLEN_RST;
		end
		else if (settingWrite && cmdReady && !powerDown)
			setting <= settingIn;
	end

	// ==================================================================
	// Pin drive: float bus and deselect memories in power down
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pins.dataOut <= '0;
			pins.dataOe <= '0;
			pins.memorySelectN <= SEL_IDLE;
		end
		else if (powerDown || !rstSync_n)
		begin
			pins.dataOut <= '0;
			pins.dataOe <= '0;
			pins.memorySelectN <= SEL_IDLE;
		end
		else
		begin
			pins.dataOut <= readData;
			pins.dataOe <= {DATA_W{!rdSync_n && !ceSync_n}};
			pins.memorySelectN <= (opState == RPD_IDLE) ? SEL_IDLE
				: memorySelectReq_n;
		end
	end
endmodule

// [rtl/rpd_pkg.sv]
package rpd_pkg;
	// ==================================================================
	// Widths
	localparam int DATA_W = 4;
	localparam int SEL_W = 4;
	localparam int RATE_W = 2;
	localparam int BITLEN_W = 1;

	// ==================================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_SETTLE_US = 10;
	localparam int OSC_SETTLE_CYC = (OSC_SETTLE_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// ==================================================================
	// Reset values
	localparam logic [SEL_W-1:0] SEL_IDLE = 4'hF;
	localparam logic [RATE_W-1:0] RATE_RST = 2'h3;
	localparam logic [BITLEN_W-1:0] BITLEN_RST = 1'h0;

	// ==================================================================
	// Types
	typedef enum logic [1:0] {
		RPD_IDLE,
		RPD_RECORD,
		RPD_PLAY
	} rpd_op_t;

	typedef struct packed {
		logic [RATE_W-1:0] sampleRate;
		logic [BITLEN_W-1:0] bitLength;
	} rpd_setting_t;

	typedef struct packed {
		logic [DATA_W-1:0] dataOut;
		logic [DATA_W-1:0] dataOe;
		logic [SEL_W-1:0] memorySelectN;
	} rpd_pins_t;
endpackage

// [rtl/rpd_settle_timer.sv]
`timescale 1ns/1ps
// ======================================================================
// Oscillator settle timer: counts cycles after power-down ends
module rpd_settle_timer
	import rpd_pkg::*;
#(
	parameter int SETTLE_CYC = OSC_SETTLE_CYC
)(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic powerDown,
	output logic settled
);
	localparam int CW = $clog2(SETTLE_CYC + 1);
	logic [CW-1:0] count;

	// Restart the count on every power-down, hold once reached
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
			settled <= 1'b0;
		end
		else if (powerDown)
		begin
			count <= '0;
			settled <= 1'b0;
		end
		else if (count == CW'(SETTLE_CYC - 1))
			settled <= 1'b1;
		else
			count <= count + CW'(1);
	end
endmodule

// [verification/rpd_asserts.sv]
`timescale 1ns/1ps
module rpd_asserts
	import rpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic powerDown,
	input wire logic oscEnable,
	input wire logic cmdReady,
	input wire rpd_op_t opState,
	input wire rpd_pins_t pins
);
	// ======
	// Power-down and wake checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_osc_off: assert property (powerDown |-> !oscEnable)
		else $error("osc on");
	chk_ctl_init: assert property (powerDown |-> opState == RPD_IDLE)
		else $error("op kept");
	chk_op_halt: assert property (powerDown |-> !cmdReady)
		else $error("ready");
	chk_bus_float: assert property (powerDown |-> pins.dataOe == 0)
		else $error("bus driven");
	chk_mem_desel: assert property
		(powerDown |-> pins.memorySelectN == SEL_IDLE) else $error("sel");
	chk_wake_wait: assert property
		($fell(powerDown) |-> !cmdReady [*4]) else $error("early");
	chk_wake_ready: assert property
		($fell(powerDown) |-> ##[1:12] cmdReady) else $error("late");
	chk_idle_hold: assert property
		(!cmdReady && opState == RPD_IDLE |=> opState == RPD_IDLE)
		else $error("taken");
	cover property ($rose(powerDown));
	cover property ($rose(cmdReady));
	cover property (opState == RPD_RECORD);
endmodule
bind rpd_reset_power_down rpd_asserts chk (.sys_clk, .rst, .powerDown,
	.oscEnable, .cmdReady, .opState, .pins);

// [verification/rpd_host_model.sv]
`timescale 1ns/1ps
module rpd_host_model (
	input wire logic sys_clk,
	input wire logic sleep,
	output logic resetPin_n,
	output logic oscillator_input
);
	// ======
	// Reset pin low while asleep; clock pin grounded then
	assign resetPin_n = !sleep;
	always @(posedge sys_clk)
		oscillator_input <= sleep ? 1'b0 : !oscillator_input;
endmodule

// [verification/reset_power_down_control_bench.sv]
`timescale 1ns/1ps
module reset_power_down_control_bench
	import rpd_pkg::*;
;
	// ======
	// Stimulus and design
	logic sys_clk = 0, rst = 1, sleep = 1, rdN = 0, cmdValid = 0, setW = 0;
	logic [1:0] cmdOp = 0;
	rpd_setting_t setIn = 3'h3;
	logic resetPin_n, oscIn, powerDown, oscEnable, cmdReady;
	rpd_op_t opState;
	rpd_setting_t setting;
	rpd_pins_t pins;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	logic [1:0] ops[4] = '{2'h1, 2'h2, 2'h0, 2'h3};
	rpd_op_t expOp[4] = '{RPD_RECORD, RPD_PLAY, RPD_IDLE, RPD_IDLE};
	always #5 sys_clk = !sys_clk;
	rpd_host_model host (.sys_clk, .sleep, .resetPin_n,
		.oscillator_input(oscIn));
	rpd_reset_power_down #(.SETTLE_CYC(4)) dut (.sys_clk, .rst, .resetPin_n,
		.oscillator_input(oscIn), .readStrobe_n(rdN), .chipEnable_n(rdN),
		.cmdValid, .cmdOp, .settingWrite(setW), .settingIn(setIn),
		.readData(4'h5), .memorySelectReq_n(4'hA), .powerDown, .oscEnable,
		.cmdReady, .opState, .setting, .pins);
	// Compare and report
	task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One command, result sampled after the taking edge
	task automatic cmd(logic [1:0] op, logic wr);
		@(posedge sys_clk);
		cmdValid <= 1;
		cmdOp <= op;
		setW <= wr;
		@(posedge sys_clk);
		cmdValid <= 0;
		setW <= 0;
		#1;
	endtask
	task automatic wake();
		sleep <= 0;
		cmd(2'h1, 0);
		check("refuse", opState, RPD_IDLE);
		for (int i = 0; i < 30 && cmdReady !== 1; i++)
		begin
			@(posedge sys_clk);
			#1;
		end
		check("ready", cmdReady, 1);
	endtask
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			final_report();
		end
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst <= 0;
		wake();
		check("setrst", setting, {RATE_RST, BITLEN_RST});
		check("drive", pins.dataOe, 4'hF);
		check("dout", pins.dataOut, 4'h5);
		for (int i = 0; i < 4; i++)
		begin
			cmd(ops[i], 0);
			check("op", opState, expOp[i]);
		end
		cmd(2'h1, 1);
		@(posedge sys_clk);
		#1;
		check("sel", pins.memorySelectN, 4'hA);
		sleep <= 1;
		repeat (6) @(posedge sys_clk);
		#1;
		check("pd", {powerDown, oscEnable, cmdReady}, 4'h4);
		check("oe", pins.dataOe, 4'h0);
		check("cs", pins.memorySelectN, 4'hF);
		check("stop", opState, RPD_IDLE);
		cmd(2'h2, 0);
		check("halt", opState, RPD_IDLE);
		wake();
		check("keep", setting, 3'h3);
		final_report();
	end
endmodule
